// file: rtl/clock_timer_divider.sv
// Function
// - All taps come from binary division of a nominal 32.768 kHz oscillator.
// - Visible timer is a 4-bit counter readable anytime without disturbing it.
// - Read gives 2 Hz on bit 3, 4 Hz bit 2, 8 Hz bit 1, 16 Hz bit 0.
// - Each visible tap is a square wave with equal high and low time.
// - Falling edges of 32 Hz, 8 Hz and 2 Hz each raise their own request.
// - Timer data is read-only; writes ignored; value after reset zero.
// - Mask bits for 2, 8, 32 Hz on bits 2, 1, 0; reset zero; one enables.
// - Flags for 2, 8, 32 Hz on bits 2, 1, 0; reset zero; cleared by read.
// - Unused bits of mask, flag and reset registers read as zero.
// - Writing one to reset bit 2 clears visible counter and restarts counting.
// - Timer reset also initializes divider stages from 128 Hz down to 2 Hz.
// - Reset bit clears itself by hardware one clock after being set.
`timescale 1ns/1ps
module clock_timer_divider
  import clock_timer_pkg::*;
#(
  parameter int unsigned CLK_HZ = clk_hz,
  parameter int unsigned OSC_HZ = osc_hz
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [addr_width-1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [data_width-1:0] io_wdata,
  output logic [data_width-1:0] io_rdata,
  output logic [2:0] irq_request
);
  // Refuse settings that the divider taps or the register map cannot serve
  initial begin
    if (OSC_HZ != osc_hz) begin
      $error("clock_timer_divider: chain taps assume the nominal oscillator rate");
    end
    if (CLK_HZ < 2 * OSC_HZ) begin
      $error("clock_timer_divider: system clock too slow for the oscillator enable");
    end
    if (data_width != 4) begin
      $error("clock_timer_divider: register words are four bits wide");
    end
    if (addr_width != 12) begin
      $error("clock_timer_divider: register addresses are twelve bits wide");
    end
    if (restart_bit >= data_width) begin
      $error("clock_timer_divider: restart bit lies outside the register word");
    end
    if (fast_tick_bit >= 3 || eighth_second_bit >= 3 || half_second_bit >= 3) begin
      $error("clock_timer_divider: flag bits lie outside the flag register");
    end
    if (stage_2hz >= chain_width || stage_128hz >= stage_32hz) begin
      $error("clock_timer_divider: divider taps lie outside the chain");
    end
    if (stage_16hz != stage_32hz + 1) begin
      $error("clock_timer_divider: fast tick source must sit just above the 16 Hz tap");
    end
    if (stage_8hz != stage_16hz + 1 || stage_4hz != stage_8hz + 1 || stage_2hz != stage_4hz + 1) begin
      $error("clock_timer_divider: visible taps must be adjacent binary stages");
    end
  end

  typedef struct packed {
    logic [chain_width-1:0] chain;
    logic restart_strobe;
    logic [2:0] irq_enable;
    logic [2:0] irq_pending;
    logic [data_width-1:0] rdata;
    logic [2:0] irq_request;
  } timer_state_type;

  timer_state_type state;
  timer_state_type next_state;
  logic osc_tick;

  // One-hot register select, one bit per mapped address
  localparam int sel_taps = 0;
  localparam int sel_enable = 1;
  localparam int sel_pending = 2;
  localparam int sel_restart = 3;
  localparam int sel_count = 4;
  localparam int rate_count = 3;

  logic [chain_width-1:0] chain_plus;
  logic [rate_count-1:0] edge_seen;
  logic [sel_count-1:0] rd_sel;
  logic [sel_count-1:0] wr_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator enable

  osc_tick_gen #(
    .CLK_HZ(CLK_HZ),
    .OSC_HZ(OSC_HZ)
  ) u_osc_tick_gen (
    .clk(clk),
    .sys_rst(sys_rst),
    .osc_tick(osc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_hit(input logic [addr_width-1:0] a, input logic [addr_width-1:0] target);
    addr_hit = (a == target);
  endfunction

  function automatic logic [sel_count-1:0] reg_select(input logic [addr_width-1:0] a);
    reg_select = '0;
    if (addr_hit(a, timer_tap_levels_addr)) begin
      reg_select[sel_taps] = 1'b1;
    end else if (addr_hit(a, timer_irq_enable_addr)) begin
      reg_select[sel_enable] = 1'b1;
    end else if (addr_hit(a, timer_irq_pending_addr)) begin
      reg_select[sel_pending] = 1'b1;
    end else if (addr_hit(a, timer_restart_control_addr)) begin
      reg_select[sel_restart] = 1'b1;
    end
  endfunction

  function automatic logic fell(input logic [chain_width-1:0] cur, input logic [chain_width-1:0] nxt,
                                input int idx);
    fell = cur[idx] & ~nxt[idx];
  endfunction

  // Mask covering the 128 Hz through 2 Hz stages
  localparam logic [chain_width-1:0] restart_mask =
    chain_width'(((1 << (stage_2hz + 1)) - 1) & ~((1 << stage_128hz) - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Decode and edge detection

  assign chain_plus = state.chain + chain_width'(1);
  assign rd_sel = io_rd ? reg_select(io_addr) : sel_count'(0);
  assign wr_sel = io_wr ? reg_select(io_addr) : sel_count'(0);

  // One falling-edge detector per interrupt rate, indexed by flag bit
  generate
    for (genvar r = 0; r < rate_count; r++) begin : g_rate
      localparam int src = (r == fast_tick_bit) ? stage_32hz :
                           (r == eighth_second_bit) ? stage_8hz : stage_2hz;
      assign edge_seen[r] = osc_tick & fell(state.chain, chain_plus, src);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [chain_width-1:0] counted;
    logic [2:0] events;
    logic [3:0] taps;
    next_state = state;
    counted = state.chain;
    events = 3'h0;
    taps = {state.chain[stage_2hz], state.chain[stage_4hz],
            state.chain[stage_8hz], state.chain[stage_16hz]};
    next_state.rdata = read_zero;

    // Plain binary chain: every stage is a 50 % square wave
    if (osc_tick) begin
      counted = chain_plus;
      events = edge_seen;
    end
    next_state.chain = counted;

    // Strobe high for one clock clears the 128 Hz..2 Hz stages, then drops
    if (state.restart_strobe) begin
      // Stages faster than 128 Hz keep counting so the oscillator phase is kept
      next_state.chain = counted & ~restart_mask;
      events = 3'h0;
    end
    next_state.restart_strobe = 1'b0;

    // Writes to the tap level and flag addresses are ignored
    if (wr_sel[sel_enable]) begin
      next_state.irq_enable = io_wdata[2:0];
    end
    if (wr_sel[sel_restart]) begin
      next_state.restart_strobe = io_wdata[restart_bit];
    end

    next_state.irq_pending = state.irq_pending;
    if (rd_sel[sel_taps]) begin
      next_state.rdata = taps;
    end
    if (rd_sel[sel_enable]) begin
      next_state.rdata = {1'b0, state.irq_enable};
    end
    if (rd_sel[sel_pending]) begin
      next_state.rdata = {1'b0, state.irq_pending};
      next_state.irq_pending = 3'h0;
    end
    if (rd_sel[sel_restart]) begin
      next_state.rdata = read_zero;
    end
    // An edge in the same cycle as the clearing read is kept
    next_state.irq_pending = next_state.irq_pending | events;
    next_state.irq_request = next_state.irq_pending & next_state.irq_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state.chain <= '0;
      state.restart_strobe <= 1'b0;
      state.irq_enable <= irq_enable_reset;
      state.irq_pending <= irq_pending_reset;
      state.rdata <= read_zero;
      state.irq_request <= 3'h0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register
  assign io_rdata = state.rdata;
  assign irq_request = state.irq_request;
endmodule

// file: rtl/clock_timer_pkg.sv
package clock_timer_pkg;
  localparam int unsigned clk_hz = 10_000_000;
  localparam int unsigned osc_hz = 32_768;
  localparam int addr_width = 12;
  localparam int data_width = 4;
  localparam logic [11:0] timer_tap_levels_addr = 12'h0e4;
  localparam logic [11:0] timer_irq_enable_addr = 12'h0eb;
  localparam logic [11:0] timer_irq_pending_addr = 12'h0ef;
  localparam logic [11:0] timer_restart_control_addr = 12'h0f9;
  localparam int restart_bit = 2;
  localparam int half_second_bit = 2;
  localparam int eighth_second_bit = 1;
  localparam int fast_tick_bit = 0;
  localparam int chain_width = 15;
  localparam int stage_128hz = 7;
  localparam int stage_32hz = 9;
  localparam int stage_16hz = 10;
  localparam int stage_8hz = 11;
  localparam int stage_4hz = 12;
  localparam int stage_2hz = 13;
  localparam logic [2:0] irq_enable_reset = 3'h0;
  localparam logic [2:0] irq_pending_reset = 3'h0;
  localparam logic [3:0] read_zero = 4'h0;
endpackage

// file: rtl/osc_tick_gen.sv
`timescale 1ns/1ps
module osc_tick_gen
  import clock_timer_pkg::*;
#(
  parameter int unsigned CLK_HZ = clk_hz,
  parameter int unsigned OSC_HZ = osc_hz
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic osc_tick
);
  initial begin
    if (OSC_HZ == 0 || OSC_HZ > CLK_HZ / 2 || CLK_HZ >= 2 ** 24) begin
      $error("osc_tick_gen: unsupported clock ratio");
    end
  end

  localparam logic [24:0] step = 25'(OSC_HZ);
  localparam logic [24:0] wrap = 25'(CLK_HZ);

  typedef struct packed {
    logic [24:0] acc;
    logic tick;
  } tick_state_type;

  tick_state_type state;
  tick_state_type next_state;

  // Fractional accumulator gives the nominal oscillator rate on average
  always_comb begin
    logic [24:0] sum;
    sum = state.acc + step;
    next_state = state;
    next_state.tick = 1'b0;
    if (sum >= wrap) begin
      next_state.acc = sum - wrap;
      next_state.tick = 1'b1;
    end else begin
      next_state.acc = sum;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign osc_tick = state.tick;
endmodule

// file: verif/clock_timer_divider_assertions.sv
`timescale 1ns/1ps
module clock_timer_divider_assertions
  import clock_timer_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [addr_width-1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [data_width-1:0] io_wdata,
  input wire logic [data_width-1:0] io_rdata,
  input wire logic [2:0] irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] mask;
  wire rd_m = io_rd && io_addr == timer_irq_enable_addr;
  wire rd_f = io_rd && io_addr == timer_irq_pending_addr;
  wire rd_r = io_rd && io_addr == timer_restart_control_addr;
  wire rd_t = io_rd && io_addr == timer_tap_levels_addr;
  wire wr_m = io_wr && io_addr == timer_irq_enable_addr;
  wire clr = rd_f || wr_m;
  sequence restart_s;
    io_wr && io_addr == timer_restart_control_addr && io_wdata[restart_bit];
  endsequence
  always_ff @(posedge clk) mask <= sys_rst ? 3'h0 : wr_m ? io_wdata[2:0] : mask;
  ////////////////////
  unused_zero_a: assert property (rd_m || rd_f || rd_r |=> !io_rdata[3]) else $error("bit 3 set");
  ctrl_unused_a: assert property (rd_r |=> io_rdata[1:0] == 2'h0) else $error("low bits set");
  mask_read_a: assert property (rd_m |=> io_rdata[2:0] == $past(mask)) else $error("mask mismatch");
  restart_tap_a: assert property (restart_s ##[2:20] rd_t |=> io_rdata == 4'h0) else $error("taps kept");
  strobe_clear_a: assert property (restart_s ##2 rd_r |=> io_rdata == 4'h0) else $error("strobe stuck");
  flag_clear_a: assert property (rd_f ##2 rd_f |=> (io_rdata & $past(io_rdata, 2)) == 4'h0)
    else $error("flag kept");
  irq_fall_a: assert property ((~irq_request & $past(irq_request)) != 3'h0 |-> $past(clr) || $past(clr, 2))
    else $error("irq dropped");
  irq_mask_a: assert property ((irq_request & ~(mask | $past(mask))) == 3'h0) else $error("masked irq");
endmodule
bind clock_timer_divider clock_timer_divider_assertions chk_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .io_addr(io_addr),
  .io_rd(io_rd),
  .io_wr(io_wr),
  .io_wdata(io_wdata),
  .io_rdata(io_rdata),
  .irq_request(irq_request)
);

// file: verif/cpu_io_model.sv
`timescale 1ns/1ps
module cpu_io_model
  import clock_timer_pkg::*;
(
  input wire logic clk,
  output logic [addr_width-1:0] io_addr,
  output logic io_rd,
  output logic io_wr,
  output logic [data_width-1:0] io_wdata,
  input wire logic [data_width-1:0] io_rdata
);
  initial {io_addr, io_rd, io_wr, io_wdata} = 18'h0;
  // Strobe one cycle; answer taken at the falling edge half a cycle after the strobe edge
  task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] wd, output logic [3:0] q);
    @(negedge clk);
    {io_addr, io_wr, io_rd, io_wdata} = {a, w, !w, wd};
    @(negedge clk);
    {io_addr, io_wr, io_rd, io_wdata} = {~a, 2'h0, ~wd};
    q = io_rdata;
  endtask
endmodule

// file: verif/clock_timer_divider_tb_top.sv
`timescale 1ns/1ps
module clock_timer_divider_tb_top
  import clock_timer_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] io_addr;
  logic io_rd;
  logic io_wr;
  logic [3:0] io_wdata;
  logic [3:0] io_rdata;
  logic [3:0] q;
  logic [2:0] irq_request;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
  always #50 clk = ~clk;
  always @(posedge clk) if (++cycles == 60000) begin err_total++; conclude(); end
  cpu_io_model cpu_io_model_i (
    .clk(clk),
    .io_addr(io_addr),
    .io_rd(io_rd),
    .io_wr(io_wr),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata)
  );
  // Run as if clocked at twice the oscillator so a 2 Hz edge comes in 32768 cycles
  clock_timer_divider #(.CLK_HZ(32'h1_0000)) clock_timer_divider_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .io_addr(io_addr),
    .io_rd(io_rd),
    .io_wr(io_wr),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata),
    .irq_request(irq_request)
  );
  ////////////////////
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    cpu_io_model_i.acc(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [11:0] a, input logic [3:0] e);
    cpu_io_model_i.acc(1'b0, a, 4'h0, q);
    `CHK(q, e)
  endtask
  task automatic wait_irq(input int k, input int lim);
    for (int n = 0; n < lim && irq_request[k] !== 1'b1; n++) @(negedge clk);
    `CHK(irq_request[k], 1'b1)
  endtask
  ////////////////////
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    rc(timer_irq_enable_addr, 4'h0);
    rc(timer_irq_pending_addr, 4'h0);
    rc(12'h0e5, 4'h0);
    wr(timer_irq_enable_addr, 4'hf);
    rc(timer_irq_enable_addr, 4'h7);
    wr(timer_restart_control_addr, 4'h4);
    rc(timer_restart_control_addr, 4'h0);
    wr(timer_tap_levels_addr, 4'hf);
    rc(timer_tap_levels_addr, 4'h0);
    wait_irq(0, 2100);
    wr(timer_restart_control_addr, 4'h0);
    rc(timer_tap_levels_addr, 4'h1);
    rc(timer_irq_pending_addr, 4'h1);
    rc(timer_irq_pending_addr, 4'h0);
    wr(timer_irq_enable_addr, 4'h6);
    wr(timer_irq_pending_addr, 4'h7);
    wait_irq(1, 6500);
    rc(timer_tap_levels_addr, 4'h4);
    // Restart with a tap high: it must drop and counting start over
    wr(timer_restart_control_addr, 4'h4);
    rc(timer_tap_levels_addr, 4'h0);
    rc(timer_irq_pending_addr, 4'h3);
    wait_irq(2, 33000);
    `CHK(irq_request, 3'h6)
    rc(timer_irq_pending_addr, 4'h7);
    // Mid-run reset returns masks, flags and requests to zero
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    `CHK(irq_request, 3'h0)
    rc(timer_irq_enable_addr, 4'h0);
    rc(timer_irq_pending_addr, 4'h0);
    conclude();
  end
endmodule
